/* hdl/ptm_params.svh */
// Register offsets, field positions, reset values and timing counts of the period timer
//
// Contract
// [RULE1] Count from zero, wrap after matching period
// [RULE2] Prescale select: 1, 4 or 16
// [RULE3] Postscaler 1:1 to 1:16 on matches
// [RULE4] Postscaler completion sets flag, enable gates it
// [RULE5] Count or control writes clear both scalers
// [RULE6] Control write leaves counter value alone
// [RULE7] Counter readable, writable, zero at reset
// [RULE8] Period readable, writable, all ones at reset
// [RULE9] Timer runs only while on bit set
// [RULE10] Control bit 7 reads zero; reset zero
// [RULE11] Raw match pulse offered to serial port
// [RULE12] Counter and match offered as PWM base
// [RULE13] Compare only on tick; one match each period
`ifndef PTM_PARAMS_SVH
`define PTM_PARAMS_SVH

`define PTM_OFF_COUNT     12'h000
`define PTM_OFF_PERIOD    12'h004
`define PTM_OFF_CONTROL   12'h008
`define PTM_OFF_FLAGS     12'h00C
`define PTM_OFF_ENABLES   12'h010
`define PTM_OFF_PRIORITY  12'h014

`define PTM_CTL_PRE_LSB   0
`define PTM_CTL_ON_BIT    2
`define PTM_CTL_POST_LSB  3
`define PTM_CTL_MASK      8'h7F
`define PTM_IRQ_BIT       1

`define PTM_RST_COUNT     8'h00
`define PTM_RST_PERIOD    8'hFF
`define PTM_RST_CONTROL   8'h00
`define PTM_RST_FLAGS     8'h00
`define PTM_RST_ENABLES   8'h00
`define PTM_RST_PRIORITY  8'hFF

`define PTM_INSTR_DIV     2'd3
`define PTM_PRE_DIV4      4'd3
`define PTM_PRE_DIV16     4'd15

`endif

/* hdl/ptm_pkg.sv */
// Types of the period timer
package ptm_pkg;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } ptm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ptm_apb_rsp_t;

    typedef struct packed {
        logic [7:0] count;
        logic       match;
    } ptm_timebase_t;

    typedef struct packed {
        logic [1:0]    instr_div;
        logic [3:0]    pre_cnt;
        logic [3:0]    post_cnt;
        logic [7:0]    count;
        logic [7:0]    period;
        logic [7:0]    control;
        logic [7:0]    flags;
        logic [7:0]    enables;
        logic [7:0]    prio;
        ptm_apb_rsp_t  rsp;
        ptm_timebase_t tb;
        logic          irq;
        logic          irq_high;
    } ptm_state_t;

endpackage

/* hdl/ptm_timer.sv */
// APB-attached 8-bit period timer with prescaler, postscaler and interrupt
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_params.svh"

module ptm_timer (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire ptm_pkg::ptm_apb_req_t  apb_req,
    output var  ptm_pkg::ptm_apb_rsp_t  apb_rsp,
    output var  ptm_pkg::ptm_timebase_t pwm_timebase,
    output var  logic                   ssp_shift_tick,
    output var  logic                   irq,
    output var  logic                   irq_high
);
    import ptm_pkg::*;

    ptm_state_t r;
    ptm_state_t next_r;

    // Prescale terminal count for the select field
    function automatic logic [3:0] pre_limit(input logic [1:0] sel);
        logic [3:0] lim;
        lim = 4'd0;
        if (sel[1]) begin
            lim = `PTM_PRE_DIV16;
        end else if (sel[0]) begin
            lim = `PTM_PRE_DIV4;
        end
        return lim;
    endfunction

    logic       instr_tick;
    logic       pre_tick;
    logic       match;
    logic       post_done;
    logic       wr;
    logic       rd;
    logic       cnt_wr;
    logic       ctl_wr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic       hit;

    always_comb begin
        next_r = r;
        wr     = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd     = apb_req.psel && apb_req.penable && !apb_req.pwrite;
        wbyte  = apb_req.pwdata[7:0];
        cnt_wr = wr && (apb_req.paddr == `PTM_OFF_COUNT);
        ctl_wr = wr && (apb_req.paddr == `PTM_OFF_CONTROL);

        // Instruction clock is the bus clock divided by four
        instr_tick = r.control[`PTM_CTL_ON_BIT] && (r.instr_div == `PTM_INSTR_DIV); // RULE9
        pre_tick   = instr_tick
                     && (r.pre_cnt == pre_limit(r.control[`PTM_CTL_PRE_LSB +: 2])); // RULE2
        match      = pre_tick && (r.count == r.period); // RULE13
        post_done  = match && (r.post_cnt == r.control[`PTM_CTL_POST_LSB +: 4]); // RULE3

        if (r.control[`PTM_CTL_ON_BIT]) begin
            next_r.instr_div = r.instr_div + 2'd1;
        end
        if (instr_tick) begin
            next_r.pre_cnt = pre_tick ? 4'd0 : r.pre_cnt + 4'd1;
        end
        if (pre_tick) begin
            next_r.count = match ? 8'h00 : r.count + 8'h01; // RULE1
        end
        if (match) begin
            next_r.post_cnt = post_done ? 4'd0 : r.post_cnt + 4'd1;
        end

        // Register writes
        if (cnt_wr) begin
            next_r.count = wbyte; // RULE7
        end
        if (wr && apb_req.paddr == `PTM_OFF_PERIOD) begin
            next_r.period = wbyte; // RULE8
        end
        if (ctl_wr) begin
            next_r.control = wbyte & `PTM_CTL_MASK; // RULE10 RULE6
        end
        if (wr && apb_req.paddr == `PTM_OFF_ENABLES) begin
            next_r.enables = wbyte;
        end
        if (wr && apb_req.paddr == `PTM_OFF_PRIORITY) begin
            next_r.prio = wbyte;
        end
        if (cnt_wr || ctl_wr) begin
            next_r.pre_cnt   = 4'd0; // RULE5
            next_r.post_cnt  = 4'd0; // RULE5
            next_r.instr_div = 2'd0;
        end

        // Write one to clear; a new event wins over the clear
        if (wr && apb_req.paddr == `PTM_OFF_FLAGS) begin
            next_r.flags = r.flags & ~wbyte;
        end
        if (post_done) begin
            next_r.flags[`PTM_IRQ_BIT] = 1'b1; // RULE4
        end

        hit = 1'b1;
        case (apb_req.paddr)
            `PTM_OFF_COUNT:    rbyte = r.count;
            `PTM_OFF_PERIOD:   rbyte = r.period;
            `PTM_OFF_CONTROL:  rbyte = r.control & `PTM_CTL_MASK; // RULE10
            `PTM_OFF_FLAGS:    rbyte = r.flags;
            `PTM_OFF_ENABLES:  rbyte = r.enables;
            `PTM_OFF_PRIORITY: rbyte = r.prio;
            default: begin
                rbyte = 8'h00;
                hit   = 1'b0;
            end
        endcase

        // Zero-wait slave: answer in the setup cycle, registered for the next
        next_r.rsp.pready  = apb_req.psel && !apb_req.penable;
        next_r.rsp.pslverr = apb_req.psel && !apb_req.penable && !hit;
        next_r.rsp.prdata  = (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
                             ? {24'h00_0000, rbyte} : 32'h0000_0000;
        if (rd) begin
            next_r.rsp.prdata = 32'h0000_0000;
        end

        next_r.tb.count = next_r.count; // RULE12
        next_r.tb.match = match; // RULE11 RULE12
        next_r.irq      = |(next_r.flags & next_r.enables); // RULE4
        next_r.irq_high = |(next_r.flags & next_r.enables & next_r.prio);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.count    <= `PTM_RST_COUNT; // RULE7 RULE5
            r.period   <= `PTM_RST_PERIOD; // RULE8
            r.control  <= `PTM_RST_CONTROL; // RULE9 RULE10
            r.flags    <= `PTM_RST_FLAGS;
            r.enables  <= `PTM_RST_ENABLES;
            r.prio     <= `PTM_RST_PRIORITY;
        end else begin
            r <= next_r;
        end
    end

    assign apb_rsp        = r.rsp;
    assign pwm_timebase   = r.tb;
    assign ssp_shift_tick = r.tb.match; // RULE11
    assign irq            = r.irq;
    assign irq_high       = r.irq_high;

endmodule
`default_nettype wire

/* verification/ptm_timer_props.sv */
// Port checker of the period timer
`timescale 1ns/1ps
`default_nettype none
module ptm_timer_props (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire ptm_pkg::ptm_apb_req_t  apb_req,
    input wire ptm_pkg::ptm_apb_rsp_t  apb_rsp,
    input wire ptm_pkg::ptm_timebase_t pwm_timebase,
    input wire logic                   ssp_shift_tick,
    input wire logic                   irq,
    input wire logic                   irq_high
);
    import ptm_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready too long");
    a_err_on_unmapped: assert property (apb_rsp.pready |->
        apb_rsp.pslverr == (apb_req.paddr > 12'h014 || apb_req.paddr[1:0] != 2'b00))
        else $error("error flag wrong");
    a_read_upper_zero: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    a_ssp_same_match: assert property (ssp_shift_tick == pwm_timebase.match)
        else $error("shift tick differs");
    a_match_wraps_zero: assert property (pwm_timebase.match |-> pwm_timebase.count == 8'h00)
        else $error("no wrap on match");
    a_match_spacing: assert property (pwm_timebase.match |=> !pwm_timebase.match [*3])
        else $error("matches too close");
    a_high_needs_irq: assert property (irq_high |-> irq)
        else $error("high irq alone");
endmodule
bind ptm_timer ptm_timer_props u_props (.pclk, .presetn, .apb_req, .apb_rsp,
    .pwm_timebase, .ssp_shift_tick, .irq, .irq_high);
`default_nettype wire

/* verification/ptm_peer.sv */
// PWM unit and serial port model counting timer matches
`timescale 1ns/1ps
`default_nettype none
module ptm_peer (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire ptm_pkg::ptm_timebase_t tbase,
    input  wire logic                   shift_tick,
    output var  logic [15:0]            n_match
);
    import ptm_pkg::*;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            n_match <= 16'h0000;
        else if (tbase.match && shift_tick)
            n_match <= n_match + 16'h0001;
    end
endmodule
`default_nettype wire

/* verification/test_period_timer_8bit.sv */
// Self-checking testbench of the period timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin n_errors++; \
    $display("mismatch %0t got %h want %h", $time, g, x); end end
module test_period_timer_8bit;
    import ptm_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    ptm_apb_req_t  req = '0;
    ptm_apb_rsp_t  rsp;
    ptm_timebase_t tbo;
    logic          sst, irq, irqh, e;
    logic [15:0]   nm, m0;
    logic [31:0]   r;
    int            n_errors = 0;
    int            tests_run = 0;
    int            n;
    logic [7:0]    rst [6] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF};
    int            per [4] = '{16, 64, 256, 256};
    always #12.5 pclk = ~pclk;
    ptm_timer u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .pwm_timebase(tbo), .ssp_shift_tick(sst), .irq(irq), .irq_high(irqh));
    ptm_peer u_peer (.pclk(pclk), .presetn(presetn), .tbase(tbo), .shift_tick(sst), .n_match(nm));
    task xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
        req <= '{a, 1'b1, 1'b0, w, {24'h00_0000, d}};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        r = rsp.prdata;
        e = rsp.pslverr;
        req <= '0;
        // Let an idle edge pass so the next setup never overwrites the release
        @(posedge pclk);
    endtask
    task gap;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (tbo.match !== 1'b1);
    endtask
    task end_sim;
        if (n_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            xfer(12'(i * 4), 1'b0, 8'h00);
            `CHK(r[7:0], rst[i])
        end
        xfer(12'h018, 1'b0, 8'h00);
        `CHK(e, 1'b1)
        xfer(12'h008, 1'b1, 8'hFB);
        xfer(12'h008, 1'b0, 8'h00);
        `CHK(r[7:0], 8'h7B)
        xfer(12'h000, 1'b1, 8'h5A);
        repeat (40) @(posedge pclk);
        xfer(12'h008, 1'b1, 8'h00);
        xfer(12'h000, 1'b0, 8'h00);
        `CHK(r[7:0], 8'h5A)
        xfer(12'h000, 1'b1, 8'h00);
        xfer(12'h004, 1'b1, 8'h03);
        for (int s = 0; s < 4; s++) begin
            xfer(12'h008, 1'b1, 8'(4 + s));
            gap();
            gap();
            `CHK(n, per[s])
        end
        xfer(12'h008, 1'b1, 8'h00);
        xfer(12'h004, 1'b1, 8'h00);
        xfer(12'h00C, 1'b1, 8'hFF);
        xfer(12'h010, 1'b1, 8'h02);
        m0 = nm;
        xfer(12'h008, 1'b1, 8'h1C);
        while (irq !== 1'b1) @(posedge pclk);
        // The peer counts the last match one edge after the flag rises
        @(posedge pclk);
        `CHK(nm - m0, 16'h0004)
        `CHK(irqh, 1'b1)
        xfer(12'h00C, 1'b0, 8'h00);
        `CHK(r[7:0], 8'h02)
        xfer(12'h010, 1'b1, 8'h00);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        xfer(12'h008, 1'b1, 8'h00);
        xfer(12'h00C, 1'b1, 8'h02);
        xfer(12'h00C, 1'b0, 8'h00);
        `CHK(r[7:0], 8'h00)
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
